// [src/usart_slave_cfg.svh]
// Register map, field positions and reset values of the synchronous slave serial port
`ifndef USART_SLAVE_CFG_SVH
`define USART_SLAVE_CFG_SVH

`define IDX_INT_FLAGS 8'h0c
`define IDX_RX_CONTROL 8'h18
`define IDX_TX_BUFFER 8'h19
`define IDX_RX_BUFFER 8'h1a
`define IDX_INT_ENABLES 8'h8c
`define IDX_TX_CONTROL 8'h98
`define IDX_BIT_RATE 8'h99

`define RECEIVE_COMPLETE_FLAG_BIT 5
`define TRANSMIT_BUFFER_EMPTY_FLAG_BIT 4
`define RECEIVE_INTERRUPT_ENABLE_BIT 5
`define TRANSMIT_INTERRUPT_ENABLE_BIT 4
`define SHIFT_REGISTER_EMPTY_BIT 1

`define INT_ENABLES_RESET 8'h00
`define BIT_RATE_RESET 8'h00
`define TX_BUFFER_RESET 8'h00
`define RX_BUFFER_RESET 8'h00
`define TX_CONTROL_RESET 6'h00
`define RX_CONTROL_RESET 5'h00

`define WORD_BITS_8 4'h8
`define WORD_BITS_9 4'h9

`endif

// [src/usart_slave_pkg.sv]
// Types shared by the synchronous slave serial port
package usart_slave_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic clockSource;
        logic nineBitTx;
        logic txEnable;
        logic syncMode;
        logic highSpeed;
        logic ninthTxBit;
    } tx_ctrl_type;

    typedef struct packed {
        logic portEnable;
        logic nineBitRx;
        logic singleRx;
        logic contRx;
        logic addrDetect;
    } rx_ctrl_type;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_type;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_SHIFT = 3'b010,
        RX_STALL = 3'b100
    } rx_state_type;

endpackage

// [src/shift_pin_sync.sv]
// Two-stage synchronisers for the link pins and shift clock edge detection
`timescale 1ns/1ps
module shift_pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic shiftClockPin,
    input wire logic serialDataIn,
    output logic shiftRise,
    output logic shiftFall,
    output logic dataSync
);
    logic [1:0] stage1Reg;
    logic [1:0] stage2Reg;
    logic clockDelayedReg;

    // Only stage2 reads stage1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1Reg <= 2'h0;
            stage2Reg <= 2'h0;
            clockDelayedReg <= 1'b0;
        end else begin
            stage1Reg <= {serialDataIn, shiftClockPin};
            stage2Reg <= stage1Reg;
            clockDelayedReg <= stage2Reg[0];
        end
    end

    assign shiftRise = stage2Reg[0] & ~clockDelayedReg;
    assign shiftFall = ~stage2Reg[0] & clockDelayedReg;
    assign dataSync = stage2Reg[1];
endmodule

// [src/usart_sync_slave.sv]
// Synchronous slave serial port with APB register access
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "usart_slave_cfg.svh"
module usart_sync_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire usart_slave_pkg::apb_req_type apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shiftClockPin,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe,
    output logic wakeRequest
);
    import usart_slave_pkg::*;

    logic shiftRise;
    logic shiftFall;
    logic dataSync;

    tx_ctrl_type txCtrlReg;
    rx_ctrl_type rxCtrlReg;
    logic [7:0] intEnableReg;
    logic [7:0] bitRateReg;
    logic [7:0] txBufferReg;
    logic [7:0] rxBufferReg;
    logic txFullReg;
    logic txFlagReg;
    logic rxFlagReg;
    logic rxNinthReg;
    logic overrunReg;
    tx_state_type txStateReg;
    logic [8:0] tsrReg;
    logic [3:0] txCountReg;
    rx_state_type rxStateReg;
    logic [8:0] rsrReg;
    logic [3:0] rxCountReg;
    logic dataOeReg;
    logic wakeReg;
    logic preadyReg;
    logic pslverrReg;
    logic [31:0] prdataReg;

    logic [7:0] readValue;
    logic addrHit;
    logic [7:0] regIndex;
    logic setupPhase;
    logic accessDone;
    logic wrDone;
    logic rdDone;
    logic wrTxBuffer;
    logic rdRxBuffer;
    logic portActive;
    logic txLoad;
    logic txLastBit;
    logic [8:0] rxShifted;
    logic [3:0] rxLength;
    logic rxDone;

    shift_pin_sync u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .shiftClockPin(shiftClockPin),
        .serialDataIn(serialDataIn),
        .shiftRise(shiftRise),
        .shiftFall(shiftFall),
        .dataSync(dataSync)
    );

    // Bus decode
    assign regIndex = apbReq.paddr[9:2];
    assign setupPhase = apbReq.psel & ~apbReq.penable;
    assign accessDone = apbReq.psel & apbReq.penable & preadyReg;
    assign wrDone = accessDone & apbReq.pwrite & ~pslverrReg;
    assign rdDone = accessDone & ~apbReq.pwrite & ~pslverrReg;
    assign wrTxBuffer = wrDone & (regIndex == `IDX_TX_BUFFER);
    assign rdRxBuffer = rdDone & (regIndex == `IDX_RX_BUFFER);

    always_comb begin
        readValue = 8'h00;
        addrHit = (apbReq.paddr[1:0] == 2'h0) && (apbReq.paddr[11:10] == 2'h0);
        case (regIndex)
            `IDX_INT_FLAGS: begin
                readValue[`RECEIVE_COMPLETE_FLAG_BIT] = rxFlagReg;
                readValue[`TRANSMIT_BUFFER_EMPTY_FLAG_BIT] = txFlagReg;
            end
            `IDX_RX_CONTROL: begin
                // Framing errors cannot occur in synchronous mode; bit 2 reads zero
                readValue = {rxCtrlReg, 1'b0, overrunReg, rxNinthReg};
            end
            `IDX_TX_BUFFER: begin
                readValue = txBufferReg;
            end
            `IDX_RX_BUFFER: begin
                readValue = rxBufferReg;
            end
            `IDX_INT_ENABLES: begin
                readValue = intEnableReg;
            end
            `IDX_TX_CONTROL: begin
                readValue = {txCtrlReg.clockSource, txCtrlReg.nineBitTx, txCtrlReg.txEnable,
                             txCtrlReg.syncMode, 1'b0, txCtrlReg.highSpeed,
                             txStateReg == TX_IDLE, txCtrlReg.ninthTxBit};
            end
            `IDX_BIT_RATE: begin
                readValue = bitRateReg;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    // Answer in the access cycle that follows every setup cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            preadyReg <= 1'b0;
            pslverrReg <= 1'b0;
            prdataReg <= 32'h0000_0000;
        end else begin
            preadyReg <= setupPhase;
            pslverrReg <= setupPhase & ~addrHit;
            if (setupPhase) begin
                prdataReg <= {24'h00_0000, readValue};
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txCtrlReg <= `TX_CONTROL_RESET;
            rxCtrlReg <= `RX_CONTROL_RESET;
            intEnableReg <= `INT_ENABLES_RESET;
            bitRateReg <= `BIT_RATE_RESET;
        end else if (wrDone) begin
            case (regIndex)
                `IDX_TX_CONTROL: begin
                    txCtrlReg <= {apbReq.pwdata[7:4], apbReq.pwdata[2], apbReq.pwdata[0]};
                end
                `IDX_RX_CONTROL: begin
                    rxCtrlReg <= apbReq.pwdata[7:3];
                end
                `IDX_INT_ENABLES: begin
                    intEnableReg <= apbReq.pwdata[7:0];
                end
                `IDX_BIT_RATE: begin
                    bitRateReg <= apbReq.pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Slave mode only while clock source select is clear
    assign portActive = rxCtrlReg.portEnable & txCtrlReg.syncMode & ~txCtrlReg.clockSource;

    // Transmit buffer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txBufferReg <= `TX_BUFFER_RESET;
        end else if (wrTxBuffer) begin
            txBufferReg <= apbReq.pwdata[7:0];
        end
    end

    // A word waits in the buffer until the shift register is free and reception is off
    assign txLoad = (txStateReg == TX_IDLE) & portActive & txCtrlReg.txEnable & txFullReg
                    & ~rxCtrlReg.contRx;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txFullReg <= 1'b0;
            txFlagReg <= 1'b0;
        end else begin
            if (wrTxBuffer) begin
                txFullReg <= 1'b1;
                txFlagReg <= 1'b0;
            end else if (txLoad) begin
                txFullReg <= 1'b0;
                txFlagReg <= 1'b1;
            end
        end
    end

    assign txLastBit = (txCountReg == 4'h1);

    // Transmit shifter: bit advances on the falling edge after the partner samples it on the rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txStateReg <= TX_IDLE;
            tsrReg <= 9'h000;
            txCountReg <= 4'h0;
        end else begin
            case (txStateReg)
                TX_IDLE: begin
                    if (txLoad) begin
                        tsrReg <= {txCtrlReg.ninthTxBit, txBufferReg};
                        txCountReg <= txCtrlReg.nineBitTx ? `WORD_BITS_9 : `WORD_BITS_8;
                        txStateReg <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (!portActive || !txCtrlReg.txEnable) begin
                        txStateReg <= TX_IDLE;
                        txCountReg <= 4'h0;
                    end else if (shiftFall) begin
                        tsrReg <= {1'b0, tsrReg[8:1]};
                        txCountReg <= txCountReg - 4'h1;
                        if (txLastBit) begin
                            txStateReg <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    txStateReg <= TX_IDLE;
                end
            endcase
        end
    end

    // Only the data pin is driven; the clock pin stays an input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dataOeReg <= 1'b0;
        end else begin
            dataOeReg <= portActive & txCtrlReg.txEnable & ~rxCtrlReg.contRx;
        end
    end

    // Receive path; single receive enable plays no part
    assign rxShifted = {dataSync, rsrReg[8:1]};
    assign rxLength = rxCtrlReg.nineBitRx ? `WORD_BITS_9 : `WORD_BITS_8;
    assign rxDone = (rxStateReg == RX_SHIFT) & shiftFall & (rxCountReg == rxLength - 4'h1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxStateReg <= RX_IDLE;
            rsrReg <= 9'h000;
            rxCountReg <= 4'h0;
            overrunReg <= 1'b0;
        end else begin
            case (rxStateReg)
                RX_IDLE: begin
                    overrunReg <= 1'b0;
                    rxCountReg <= 4'h0;
                    if (portActive && rxCtrlReg.contRx && txStateReg == TX_IDLE) begin
                        rxStateReg <= RX_SHIFT;
                    end
                end
                RX_SHIFT: begin
                    if (!portActive || !rxCtrlReg.contRx) begin
                        rxStateReg <= RX_IDLE;
                    end else if (shiftFall) begin
                        rsrReg <= rxShifted;
                        rxCountReg <= rxCountReg + 4'h1;
                        if (rxDone) begin
                            rxCountReg <= 4'h0;
                            if (rxFlagReg && !rdRxBuffer) begin
                                overrunReg <= 1'b1;
                                rxStateReg <= RX_STALL;
                            end
                        end
                    end
                end
                RX_STALL: begin
                    if (!rxCtrlReg.contRx) begin
                        rxStateReg <= RX_IDLE;
                    end
                end
                default: begin
                    rxStateReg <= RX_IDLE;
                end
            endcase
        end
    end

    // Receive buffer and complete flag; a new word wins over a clearing read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxBufferReg <= `RX_BUFFER_RESET;
            rxNinthReg <= 1'b0;
            rxFlagReg <= 1'b0;
        end else begin
            if (rxDone && portActive && rxCtrlReg.contRx && (!rxFlagReg || rdRxBuffer)) begin
                rxBufferReg <= rxCtrlReg.nineBitRx ? rxShifted[7:0] : rxShifted[8:1];
                rxNinthReg <= rxCtrlReg.nineBitRx & rxShifted[8];
                rxFlagReg <= 1'b1;
            end else if (rdRxBuffer) begin
                rxFlagReg <= 1'b0;
            end
        end
    end

    // Wake request for the core's interrupt logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeReg <= 1'b0;
        end else begin
            wakeReg <= (txFlagReg & intEnableReg[`TRANSMIT_INTERRUPT_ENABLE_BIT])
                       | (rxFlagReg & intEnableReg[`RECEIVE_INTERRUPT_ENABLE_BIT]);
        end
    end

    assign prdata = prdataReg;
    assign pready = preadyReg;
    assign pslverr = pslverrReg;
    assign serialDataOut = tsrReg[0];
    assign serialDataOe = dataOeReg;
    assign wakeRequest = wakeReg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_tx_load_flag: assert property (txLoad && !wrTxBuffer |=> txFlagReg && !txFullReg)
        else $error("buffer-empty flag not set on transfer");

    a_tx_write_clear: assert property (wrTxBuffer |=> !txFlagReg && txFullReg)
        else $error("buffer write did not clear empty flag");

    a_tx_word_len: assert property (txLoad |=> txStateReg == TX_SHIFT
                                    && txCountReg == ($past(txCtrlReg.nineBitTx) ? 4'h9 : 4'h8))
        else $error("wrong transmit word length");

    a_tx_last_bit: assert property (txStateReg == TX_SHIFT && portActive && txCtrlReg.txEnable
                                    && shiftFall && txLastBit |=> txStateReg == TX_IDLE)
        else $error("shift register not empty after last bit");

    a_half_duplex: assert property (!(txStateReg == TX_SHIFT && rxStateReg == RX_SHIFT))
        else $error("transmit and receive active together");

    a_rx_complete: assert property (rxDone && portActive && rxCtrlReg.contRx && !rxFlagReg
                                    |=> rxFlagReg && rxBufferReg == ($past(rxCtrlReg.nineBitRx)
                                    ? $past(rxShifted[7:0]) : $past(rxShifted[8:1])))
        else $error("received word not delivered");

    a_error_clear: assert property ($fell(rxCtrlReg.contRx) |=> ##1 !overrunReg
                                    && rxStateReg == RX_IDLE)
        else $error("error not cleared with continuous receive");

    a_wake_tx: assert property (txFlagReg && intEnableReg[`TRANSMIT_INTERRUPT_ENABLE_BIT] |=> wakeRequest)
        else $error("no wake on empty transmit buffer");

    a_wake_rx_off: assert property (!rxFlagReg && !txFlagReg |=> !wakeRequest)
        else $error("wake without a pending flag");

    a_bus_answer: assert property (setupPhase |=> pready ##1 !pready)
        else $error("bus answer not one cycle");

    c_tx_word: cover property (txLoad ##[1:1000] txStateReg == TX_IDLE);
    c_two_words: cover property (txLoad ##[1:1000] txLoad);
    c_rx_word: cover property (rxDone && !rxFlagReg);
    c_overrun: cover property (rxStateReg == RX_STALL);
endmodule

// [tb/sync_master_model.sv]
// Behavioural external master that clocks words in and out of the slave port
`timescale 1ns/1ps
module sync_master_model (
    output logic shiftClock,
    output logic masterData,
    input wire logic dataLine
);
    initial begin
        shiftClock = 1'b0;
        masterData = 1'b0;
    end

    // One frame: clock idles low between frames, each bit is a rise then a fall, 64 ns per bit
    task automatic frame(input logic [8:0] sendBits, input int nBits, output logic [8:0] gotBits);
        gotBits = 9'h000;
        #3;
        for (int i = 0; i < nBits; i++) begin
            masterData = sendBits[i];
            #16 shiftClock = 1'b1;
            gotBits[i] = dataLine;
            #32 shiftClock = 1'b0;
            #16; // data held past the falling edge before it changes
        end
        // Released line must not keep showing the last bit
        masterData = ~masterData;
    endtask
endmodule

// [tb/usart_sync_slave_tb.sv]
// Self-checking testbench for the synchronous slave serial port
`timescale 1ns/1ps
`include "usart_slave_cfg.svh"
module usart_sync_slave_tb;
    import usart_slave_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    apb_req_type apbReq = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic serialDataOut;
    logic serialDataOe;
    logic wakeRequest;
    logic shiftClock;
    logic masterData;
    logic dataLine;
    logic [31:0] rdData;
    logic rdErr;
    logic [8:0] got;
    int err_total = 0;
    int num_checks = 0;

    assign dataLine = serialDataOe ? serialDataOut : masterData;
    always #2.5 clk = ~clk;

    usart_sync_slave i_usart_sync_slave (
        .clk(clk),
        .rst_n(rst_n),
        .apbReq(apbReq),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .shiftClockPin(shiftClock),
        .serialDataIn(dataLine),
        .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe),
        .wakeRequest(wakeRequest)
    );

    sync_master_model i_sync_master_model (
        .shiftClock(shiftClock),
        .masterData(masterData),
        .dataLine(dataLine)
    );

    task automatic chk(input logic [31:0] gotVal, input logic [31:0] expVal, input string what);
        num_checks++;
        if (gotVal !== expVal) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, gotVal, expVal);
        end
    endtask

    // Waits for ready as long as it takes; only the watchdog ends a hung transfer
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wdata);
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, 2'b00}, pwdata: {24'h0, wdata}};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        apbReq <= '0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wdata);
        apb(1'b1, idx, wdata);
        chk({31'h0, rdErr}, 32'h0, "write error");
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] expVal);
        apb(1'b0, idx, 8'h00);
        chk(rdData, {24'h0, expVal}, "register read");
        chk({31'h0, rdErr}, 32'h0, "read error");
    endtask

    // Frames start on a falling system edge so link pins never change on a sampling edge
    task automatic xfer(input logic [8:0] sendBits, input int nBits);
        @(negedge clk);
        i_sync_master_model.frame(sendBits, nBits, got);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(`IDX_INT_FLAGS, 8'h00);
        rd(`IDX_RX_CONTROL, 8'h00);
        rd(`IDX_TX_BUFFER, 8'h00);
        rd(`IDX_RX_BUFFER, 8'h00);
        rd(`IDX_INT_ENABLES, 8'h00);
        rd(`IDX_TX_CONTROL, 8'h02);
        rd(`IDX_BIT_RATE, 8'h00);
        wr(`IDX_BIT_RATE, 8'ha5);
        rd(`IDX_BIT_RATE, 8'ha5);
        apb(1'b0, 8'h04, 8'h00);
        chk({31'h0, rdErr}, 32'h1, "unmapped error");
        chk(rdData, 32'h0, "unmapped data");
        $display("test reset values done");

        // Two words queued: the second waits in the buffer
        wr(`IDX_RX_CONTROL, 8'h80);
        wr(`IDX_INT_ENABLES, 8'h10);
        wr(`IDX_TX_CONTROL, 8'h30);
        wr(`IDX_TX_BUFFER, 8'ha6);
        wr(`IDX_TX_BUFFER, 8'h59);
        rd(`IDX_INT_FLAGS, 8'h00);
        rd(`IDX_TX_CONTROL, 8'h30);
        chk({31'h0, wakeRequest}, 32'h0, "early wake");
        chk({31'h0, serialDataOe}, 32'h1, "data pin enable");
        xfer(9'h000, 8);
        chk({23'h0, got}, 32'h0a6, "first word");
        rd(`IDX_INT_FLAGS, 8'h10);
        chk({31'h0, wakeRequest}, 32'h1, "transmit wake");
        wr(`IDX_INT_FLAGS, 8'h00);
        rd(`IDX_INT_FLAGS, 8'h10);
        xfer(9'h000, 8);
        chk({23'h0, got}, 32'h059, "second word");
        rd(`IDX_TX_CONTROL, 8'h32);
        $display("test queued transmit done");

        wr(`IDX_TX_CONTROL, 8'h71);
        wr(`IDX_TX_BUFFER, 8'h3c);
        xfer(9'h000, 9);
        chk({23'h0, got}, 32'h13c, "nine bit word");
        wr(`IDX_TX_CONTROL, 8'hb0);
        rd(`IDX_TX_CONTROL, 8'hb2);
        chk({31'h0, serialDataOe}, 32'h0, "master mode pin");
        $display("test nine bit transmit done");

        // Single receive enable alone must not receive
        wr(`IDX_TX_CONTROL, 8'h10);
        wr(`IDX_RX_CONTROL, 8'ha0);
        wr(`IDX_INT_ENABLES, 8'h20);
        xfer(9'h05a, 8);
        rd(`IDX_INT_FLAGS, 8'h10);
        chk({31'h0, wakeRequest}, 32'h0, "masked wake");
        wr(`IDX_RX_CONTROL, 8'h90);
        xfer(9'h05a, 8);
        rd(`IDX_INT_FLAGS, 8'h30);
        chk({31'h0, wakeRequest}, 32'h1, "receive wake");
        rd(`IDX_RX_CONTROL, 8'h90);
        rd(`IDX_RX_BUFFER, 8'h5a);
        rd(`IDX_INT_FLAGS, 8'h10);
        wr(`IDX_RX_CONTROL, 8'hd0);
        xfer(9'h1a5, 9);
        rd(`IDX_RX_CONTROL, 8'hd1);
        rd(`IDX_RX_BUFFER, 8'ha5);
        $display("test receive done");

        // Overrun while a transmit word waits behind continuous receive
        wr(`IDX_RX_CONTROL, 8'h90);
        wr(`IDX_TX_CONTROL, 8'h30);
        wr(`IDX_TX_BUFFER, 8'h77);
        rd(`IDX_TX_CONTROL, 8'h32);
        chk({31'h0, serialDataOe}, 32'h0, "pin during receive");
        xfer(9'h011, 8);
        xfer(9'h022, 8);
        rd(`IDX_RX_CONTROL, 8'h92);
        wr(`IDX_RX_CONTROL, 8'h80);
        // The receiver leaves its stalled state and drops the error over the next two cycles
        repeat (2) @(posedge clk);
        rd(`IDX_RX_CONTROL, 8'h80);
        rd(`IDX_RX_BUFFER, 8'h11);
        rd(`IDX_TX_CONTROL, 8'h30);
        chk({31'h0, serialDataOe}, 32'h1, "pin after receive");
        xfer(9'h000, 8);
        chk({23'h0, got}, 32'h077, "held word");
        $display("test overrun and half duplex done");
        report_and_stop();
    end
endmodule
